// File: src/operand_mode_and_stack_sequencer.sv
//
// Contract
// (RQ1) pc autoincrement takes operand from next word, then steps past it
// (RQ2) deferred pc autoincrement uses next word as absolute address
// (RQ3) relative mode adds offset word to pc already past it
// (RQ4) deferred relative reads computed location as pointer to operand
// (RQ5) two-operand classes resolve source and destination; single ones only destination
// (RQ6) byte operations step general registers by one; the deferred modes step them by two
// (RQ7) stack pointer and program counter always step by two
// (RQ8) operate instructions run no operand address calculation
// (RQ9) call pushes link register, copies program counter into it, then jumps
// (RQ10) return loads program counter from link, then pops link from stack
// (RQ11) acknowledged peripheral presents its vector during the acknowledge
// (RQ12) interrupt entry pushes status and pc, then loads both from vector
// (RQ13) interrupts are accepted inside a running service routine too
// (RQ14) traps on odd access, trap instructions and completed trace instructions
// (RQ15) trap entry saves pc and status, loads them from cause vector
// (RQ16) interrupt return pops pc then status word
// (RQ17) autodecrement steps before use, autoincrement after use
// (RQ18) odd word reference is illegal and traps
// (RQ19) entry pushes status first so return pops pc first
`timescale 1ns/1ns
module operand_mode_and_stack_sequencer (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // decoded instruction
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire opseq_pkg::op_t cmd_op,
  input wire logic cmd_byte,
  input wire logic [2:0] cmd_src_mode,
  input wire logic [2:0] cmd_src_reg,
  input wire logic [2:0] cmd_dst_mode,
  input wire logic [2:0] cmd_dst_reg,
  input wire logic [2:0] cmd_link_reg,
  input wire logic [15:0] cmd_vector,
  // peripheral interrupt
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  output logic irq_ack,
  // memory bus
  output logic mem_req,
  output logic mem_we,
  output logic mem_word,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  // results and state
  output logic op_done,
  output logic [15:0] src_addr,
  output logic [15:0] dst_addr,
  output logic [15:0] pc_out,
  output logic [15:0] sp_out,
  output logic [15:0] processor_status_word
);
  import opseq_pkg::*;

  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  typedef enum logic [18:0] {
    S_IDLE = 19'h00001, S_ADDR = 19'h00002, S_IDX = 19'h00004,
    S_PTR = 19'h00008, S_CALL_PUSH = 19'h00010, S_CALL_LINK = 19'h00020,
    S_CALL_JMP = 19'h00040, S_RET = 19'h00080, S_RET_POP = 19'h00100,
    S_RET_SP = 19'h00200, S_ACK = 19'h00400, S_PSH_PSW = 19'h00800,
    S_PSH_PC = 19'h01000, S_VEC_PC = 19'h02000, S_VEC_PSW = 19'h04000,
    S_POP_PC = 19'h08000, S_POP_SPA = 19'h10000, S_POP_PSW = 19'h20000,
    S_DONE = 19'h40000
  } state_t;

  state_t state_ff, nxt_state;
  mem_if mif ();
  logic [15:0] regs_ff [8];
  logic [15:0] psw_ff, nxt_psw, tmp_ff, nxt_tmp, vec_ff, nxt_vec;
  logic [15:0] src_addr_ff, dst_addr_ff, rf_val, opnd_val;
  logic [2:0] src_mode_ff, src_reg_ff, dst_mode_ff, dst_reg_ff, link_ff, rf_idx;
  logic phase_ff, nxt_phase, byte_ff, tbit_ff, done_ff, rf_we, opnd_fin, take;
  logic irq_s1_ff, irq_s2_ff;
  op_t op_ff;

  wire [2:0] cur_mode = phase_ff ? dst_mode_ff : src_mode_ff;
  wire [2:0] cur_reg = phase_ff ? dst_reg_ff : src_reg_ff;
  wire [15:0] cur_rv = regs_ff[cur_reg];
  wire [15:0] pc_v = regs_ff[PC_IDX];
  wire [15:0] sp_v = regs_ff[SP_IDX];
  wire ptr_table = (cur_mode == MODE_INC_DEF) || (cur_mode == MODE_DEC_DEF);
  wire byte_gpr = byte_ff && (cur_reg < SP_IDX) && !ptr_table;
  wire [15:0] step_v = byte_gpr ? BYTE_STEP : WORD_STEP; // [RQ6] [RQ7]
  wire [15:0] inc_v = cur_rv + step_v;
  wire [15:0] dec_v = cur_rv - step_v;
  wire [15:0] sp_dn = sp_v - WORD_STEP;
  wire [15:0] sp_up = sp_v + WORD_STEP;
  wire [15:0] idx_v = tmp_ff + cur_rv;
  wire mdone = mif.done && !mif.odd_err;
  wire odd_hit = mif.done && mif.odd_err;

  mem_port_ctl u_mem (
    .clk(clk), .sys_rst(sys_rst), .mif(mif),
    .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack)
  );

  // ---------------------------------------------------------------
  // irq pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    irq_s1_ff <= sys_rst ? 1'b0 : irq_req;
    irq_s2_ff <= sys_rst ? 1'b0 : irq_s1_ff;
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_psw = psw_ff;
    nxt_tmp = tmp_ff;
    nxt_vec = vec_ff;
    nxt_phase = phase_ff;
    rf_we = 1'b0;
    rf_idx = PC_IDX;
    rf_val = 16'h0000;
    opnd_fin = 1'b0;
    opnd_val = 16'h0000;
    cmd_ready = 1'b0;
    irq_ack = 1'b0;
    take = 1'b0;
    mif.go = 1'b0;
    mif.we = 1'b0;
    mif.word = 1'b1;
    mif.addr = 16'h0000;
    mif.wdata = 16'h0000;
    unique case (state_ff)
      S_IDLE:
      begin
        // nested service is fine: no gating on being in a routine
        if (irq_s2_ff)
          nxt_state = S_ACK; // [RQ13]
        else
        begin
          cmd_ready = 1'b1;
          take = cmd_valid;
          nxt_phase = (cmd_op != OP_DOUBLE); // [RQ5]
          nxt_vec = cmd_vector;
          if (cmd_valid)
            unique case (cmd_op)
              OP_OPERATE: nxt_state = S_DONE; // [RQ8]
              OP_RETURN: nxt_state = S_RET;
              OP_RTI: nxt_state = S_POP_PC;
              OP_TRAP: nxt_state = S_PSH_PSW; // [RQ14]
              default: nxt_state = S_ADDR;
            endcase
        end
      end
      S_ADDR:
        unique case (cur_mode)
          MODE_REG, MODE_DEF:
          begin
            opnd_fin = 1'b1;
            opnd_val = cur_rv;
          end
          MODE_INC:
          begin
            // autoincrement on pc yields the immediate word's address
            opnd_fin = 1'b1; // [RQ1] [RQ17]
            opnd_val = cur_rv;
            {rf_we, rf_idx, rf_val} = {1'b1, cur_reg, inc_v};
          end
          MODE_DEC:
          begin
            opnd_fin = 1'b1; // [RQ17]
            opnd_val = dec_v;
            {rf_we, rf_idx, rf_val} = {1'b1, cur_reg, dec_v};
          end
          MODE_INC_DEF, MODE_DEC_DEF:
          begin
            mif.go = 1'b1;
            mif.addr = (cur_mode == MODE_INC_DEF) ? cur_rv : dec_v;
            opnd_fin = mdone; // [RQ2]
            opnd_val = mif.rdata;
            rf_we = mdone;
            rf_idx = cur_reg;
            rf_val = (cur_mode == MODE_INC_DEF) ? inc_v : dec_v;
          end
          default:
          begin
            // offset word first; pc is past it before the add
            mif.go = 1'b1;
            mif.addr = pc_v;
            nxt_tmp = mdone ? mif.rdata : tmp_ff;
            {rf_we, rf_idx, rf_val} = {mdone, PC_IDX, pc_v + WORD_STEP}; // [RQ3]
            nxt_state = mdone ? S_IDX : S_ADDR;
          end
        endcase
      S_IDX:
      begin
        opnd_fin = (cur_mode == MODE_IDX); // [RQ3]
        opnd_val = idx_v;
        nxt_tmp = idx_v;
        nxt_state = S_PTR;
      end
      S_PTR:
      begin
        mif.go = 1'b1;
        mif.addr = tmp_ff;
        opnd_fin = mdone; // [RQ4]
        opnd_val = mif.rdata;
      end
      S_CALL_PUSH:
      begin
        mif.go = 1'b1;
        mif.we = 1'b1;
        mif.addr = sp_dn;
        mif.wdata = regs_ff[link_ff]; // [RQ9]
        {rf_we, rf_idx, rf_val} = {mdone, SP_IDX, sp_dn};
        nxt_state = mdone ? S_CALL_LINK : S_CALL_PUSH;
      end
      S_CALL_LINK:
      begin
        {rf_we, rf_idx, rf_val} = {1'b1, link_ff, pc_v}; // [RQ9]
        nxt_state = S_CALL_JMP;
      end
      S_CALL_JMP:
      begin
        {rf_we, rf_idx, rf_val} = {1'b1, PC_IDX, dst_addr_ff}; // [RQ9]
        nxt_state = S_DONE;
      end
      S_RET:
      begin
        {rf_we, rf_idx, rf_val} = {1'b1, PC_IDX, regs_ff[link_ff]}; // [RQ10]
        nxt_state = S_RET_POP;
      end
      S_RET_POP:
      begin
        mif.go = 1'b1;
        mif.addr = sp_v;
        {rf_we, rf_idx, rf_val} = {mdone, link_ff, mif.rdata}; // [RQ10]
        nxt_state = mdone ? S_RET_SP : S_RET_POP;
      end
      S_RET_SP:
      begin
        {rf_we, rf_idx, rf_val} = {1'b1, SP_IDX, sp_up};
        nxt_state = S_DONE;
      end
      S_ACK:
      begin
        // peripheral holds its vector while the acknowledge is high
        irq_ack = 1'b1; // [RQ11]
        nxt_vec = irq_vector;
        nxt_state = S_PSH_PSW;
      end
      S_PSH_PSW, S_PSH_PC:
      begin
        mif.go = 1'b1;
        mif.we = 1'b1;
        mif.addr = sp_dn;
        mif.wdata = (state_ff == S_PSH_PSW) ? psw_ff : pc_v; // [RQ19] [RQ12] [RQ15]
        {rf_we, rf_idx, rf_val} = {mdone, SP_IDX, sp_dn};
        if (mdone)
          nxt_state = (state_ff == S_PSH_PSW) ? S_PSH_PC : S_VEC_PC;
      end
      S_VEC_PC:
      begin
        mif.go = 1'b1;
        mif.addr = vec_ff;
        {rf_we, rf_idx, rf_val} = {mdone, PC_IDX, mif.rdata}; // [RQ12] [RQ15]
        nxt_state = mdone ? S_VEC_PSW : S_VEC_PC;
      end
      S_VEC_PSW:
      begin
        mif.go = 1'b1;
        mif.addr = vec_ff + WORD_STEP;
        nxt_psw = mdone ? mif.rdata : psw_ff;
        nxt_state = mdone ? S_IDLE : S_VEC_PSW;
      end
      S_POP_PC:
      begin
        mif.go = 1'b1;
        mif.addr = sp_v;
        {rf_we, rf_idx, rf_val} = {mdone, PC_IDX, mif.rdata}; // [RQ16]
        nxt_state = mdone ? S_POP_SPA : S_POP_PC;
      end
      S_POP_SPA:
      begin
        {rf_we, rf_idx, rf_val} = {1'b1, SP_IDX, sp_up};
        nxt_state = S_POP_PSW;
      end
      S_POP_PSW:
      begin
        mif.go = 1'b1;
        mif.addr = sp_v;
        nxt_psw = mdone ? mif.rdata : psw_ff; // [RQ16]
        {rf_we, rf_idx, rf_val} = {mdone, SP_IDX, sp_up};
        nxt_state = mdone ? S_DONE : S_POP_PSW;
      end
      S_DONE:
      begin
        // trace trap after the instruction that was fetched with t set
        nxt_vec = VEC_TRACE; // [RQ14]
        nxt_state = tbit_ff ? S_PSH_PSW : S_IDLE;
      end
      default: nxt_state = S_IDLE;
    endcase
    if (opnd_fin)
    begin
      nxt_phase = 1'b1;
      if (!phase_ff)
        nxt_state = S_ADDR; // [RQ5]
      else
        nxt_state = (op_ff == OP_CALL) ? S_CALL_PUSH : S_DONE;
    end
    // a fault during stacking repeats the entry; no double-fault halt
    if (odd_hit)
    begin
      {rf_we, opnd_fin, nxt_psw, nxt_vec} = {2'b00, psw_ff, VEC_ODD}; // [RQ18] [RQ14]
      nxt_state = S_PSH_PSW;
    end
  end

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  for (genvar gi = 0; gi < 8; gi++)
  begin : g_regs
    localparam logic [15:0] RV = (gi == 6) ? SP_RST : ((gi == 7) ? PC_RST : GPR_RST);
    always_ff @(posedge clk)
    begin
      if (sys_rst)
        regs_ff[gi] <= RV;
      else if (rf_we && (rf_idx == 3'(gi)))
        regs_ff[gi] <= rf_val;
    end
  end

  always_ff @(posedge clk)
  begin
    state_ff <= sys_rst ? S_IDLE : nxt_state;
    psw_ff <= sys_rst ? PSW_RST : nxt_psw;
    tmp_ff <= sys_rst ? 16'h0000 : nxt_tmp;
    vec_ff <= sys_rst ? 16'h0000 : nxt_vec;
    phase_ff <= sys_rst ? 1'b0 : nxt_phase;
    done_ff <= sys_rst ? 1'b0 : (state_ff == S_DONE);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      {op_ff, byte_ff, tbit_ff, link_ff} <= {OP_OPERATE, 2'b00, 3'h0};
    else if (take)
      {op_ff, byte_ff, tbit_ff, link_ff} <= {cmd_op, cmd_byte, psw_ff[TBIT_POS], cmd_link_reg};
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      {src_mode_ff, src_reg_ff, dst_mode_ff, dst_reg_ff} <= 12'h000;
    else if (take)
      {src_mode_ff, src_reg_ff, dst_mode_ff, dst_reg_ff} <=
        {cmd_src_mode, cmd_src_reg, cmd_dst_mode, cmd_dst_reg};
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      {src_addr_ff, dst_addr_ff} <= 32'h0000_0000;
    else if (opnd_fin && !phase_ff)
      src_addr_ff <= opnd_val;
    else if (opnd_fin)
      dst_addr_ff <= opnd_val;
  end

  assign op_done = done_ff;
  assign src_addr = src_addr_ff;
  assign dst_addr = dst_addr_ff;
  assign pc_out = pc_v;
  assign sp_out = sp_v;
  assign processor_status_word = psw_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_imm;
    (opnd_fin && cur_mode == MODE_INC && cur_reg == PC_IDX && phase_ff)
      |=> (pc_v == $past(pc_v) + WORD_STEP) && (dst_addr_ff == $past(pc_v));
  endproperty
  a_imm: assert property (p_imm) else $error("immediate step wrong"); // [RQ1]

  property p_rel;
    (state_ff == S_IDX && cur_mode == MODE_IDX && cur_reg == PC_IDX)
      |=> ($past(phase_ff) ? dst_addr_ff : src_addr_ff) == $past(tmp_ff) + $past(pc_v);
  endproperty
  a_rel: assert property (p_rel) else $error("relative address wrong"); // [RQ3]

  property p_byte_step;
    (opnd_fin && cur_mode == MODE_INC && byte_ff && cur_reg < SP_IDX)
      |=> regs_ff[$past(cur_reg)] == $past(cur_rv) + BYTE_STEP;
  endproperty
  a_byte_step: assert property (p_byte_step) else $error("byte step not one"); // [RQ6]

  property p_wide_step;
    (opnd_fin && cur_mode == MODE_DEC && cur_reg >= SP_IDX)
      |=> regs_ff[$past(cur_reg)] == $past(cur_rv) - WORD_STEP;
  endproperty
  a_wide_step: assert property (p_wide_step) else $error("sp/pc step not two"); // [RQ7]

  property p_predec;
    (opnd_fin && cur_mode == MODE_DEC && !phase_ff) |=> src_addr_ff == $past(dec_v);
  endproperty
  a_predec: assert property (p_predec) else $error("predecrement used old value"); // [RQ17]

  property p_operate;
    (take && cmd_op == OP_OPERATE) |=> (state_ff == S_DONE) ##1 op_done;
  endproperty
  a_operate: assert property (p_operate) else $error("operate took operand path"); // [RQ8]

  sequence s_ack;
    irq_ack ##1 (state_ff == S_PSH_PSW);
  endsequence
  property p_entry;
    s_ack |-> mif.we && (mif.wdata == psw_ff) && (mif.addr == sp_v - WORD_STEP);
  endproperty
  a_entry: assert property (p_entry) else $error("entry did not push status first"); // [RQ19]

  property p_call;
    (state_ff == S_CALL_PUSH && mdone)
      |-> (mif.wdata == regs_ff[link_ff]) ##1 (state_ff == S_CALL_LINK) ##2 (pc_v == dst_addr_ff);
  endproperty
  a_call: assert property (p_call) else $error("call sequence wrong"); // [RQ9]

  property p_ret;
    (state_ff == S_RET) |=> pc_v == $past(regs_ff[link_ff]);
  endproperty
  a_ret: assert property (p_ret) else $error("return pc not from link"); // [RQ10]

  property p_trace;
    (state_ff == S_DONE && tbit_ff) |=> (state_ff == S_PSH_PSW) && (vec_ff == VEC_TRACE);
  endproperty
  a_trace: assert property (p_trace) else $error("trace trap missed"); // [RQ14]

  property p_rti;
    (state_ff == S_POP_PC && mdone) |=> pc_v == $past(mif.rdata);
  endproperty
  a_rti: assert property (p_rti) else $error("rti pc pop wrong"); // [RQ16]

endmodule : operand_mode_and_stack_sequencer

// File: src/opseq_pkg.sv
package opseq_pkg;

  // ---------------------------------------------------------------
  // widths and register indices
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam logic [2:0] SP_IDX = 3'h6;
  localparam logic [2:0] PC_IDX = 3'h7;

  // ---------------------------------------------------------------
  // pointer steps
  // ---------------------------------------------------------------
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [15:0] GPR_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h1000;
  localparam logic [15:0] PC_RST = 16'h0200;
  localparam logic [15:0] PSW_RST = 16'h0000;

  // ---------------------------------------------------------------
  // status word fields and trap vectors
  // ---------------------------------------------------------------
  localparam int unsigned TBIT_POS = 4;
  localparam logic [15:0] VEC_ODD = 16'h0004;
  localparam logic [15:0] VEC_TRACE = 16'h000c;

  // ---------------------------------------------------------------
  // operand address modes
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_REG = 3'h0;
  localparam logic [2:0] MODE_DEF = 3'h1;
  localparam logic [2:0] MODE_INC = 3'h2;
  localparam logic [2:0] MODE_INC_DEF = 3'h3;
  localparam logic [2:0] MODE_DEC = 3'h4;
  localparam logic [2:0] MODE_DEC_DEF = 3'h5;
  localparam logic [2:0] MODE_IDX = 3'h6;
  localparam logic [2:0] MODE_IDX_DEF = 3'h7;

  // ---------------------------------------------------------------
  // instruction classes from the decoder
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_OPERATE = 3'h0,
    OP_DOUBLE = 3'h1,
    OP_SINGLE = 3'h2,
    OP_CALL = 3'h3,
    OP_RETURN = 3'h4,
    OP_RTI = 3'h5,
    OP_TRAP = 3'h6
  } op_t;

endpackage : opseq_pkg

// File: src/mem_if.sv
`timescale 1ns/1ns
interface mem_if;
  logic go;
  logic we;
  logic word;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic done;
  logic odd_err;

  modport seq (output go, we, word, addr, wdata, input rdata, done, odd_err);
  modport port (input go, we, word, addr, wdata, output rdata, done, odd_err);
endinterface : mem_if

// File: src/mem_port_ctl.sv
`timescale 1ns/1ns
module mem_port_ctl (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // sequencer side
  mem_if.port mif,
  // memory bus side
  output logic mem_req,
  output logic mem_we,
  output logic mem_word,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);
  import opseq_pkg::*;

  wire odd_word;

  // odd word reference never reaches the bus
  assign odd_word = mif.go & mif.word & mif.addr[0]; // [RQ18]
  assign mem_req = mif.go & ~odd_word;
  assign mem_we = mif.we;
  assign mem_word = mif.word;
  assign mem_addr = mif.addr;
  assign mem_wdata = mif.wdata;
  assign mif.rdata = mem_rdata;
  assign mif.done = odd_word | (mem_req & mem_ack);
  assign mif.odd_err = odd_word;

  property p_odd_blocked;
    @(posedge clk) disable iff (sys_rst)
    (mif.go && mif.word && mif.addr[0]) |-> (!mem_req && mif.done && mif.odd_err);
  endproperty
  a_odd_blocked: assert property (p_odd_blocked) // [RQ18]
    else $error("odd word access reached the bus");

endmodule : mem_port_ctl

// File: verif/far_side.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// memory and interrupting peripheral
// ---------------------------------------------------------------
module far_side (
  // clock
  input wire logic clk,
  // memory bus
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  // interrupt
  input wire logic irq_ack,
  output logic irq_req,
  output logic [15:0] irq_vector
);
  logic [15:0] mem [0:32767];
  logic [15:0] last_ff = 16'h0000, vec = 16'h0000;
  logic acked = 1'b0;
  logic [31:0] wq [$];
  int lat = 0, cnt = 0;
  // idle bus shows inverse of last value, so a stale read cannot pass
  assign mem_rdata = mem_ack ? mem[mem_addr[15:1]] : ~last_ff;
  // vector valid only in the acknowledge cycle
  assign irq_vector = irq_ack ? vec : ~vec;
  initial
  begin
    foreach (mem[i])
      mem[i] = 16'h0000;
    mem_ack = 1'b0;
    irq_req = 1'b0;
  end
  always @(posedge clk)
  begin
    if (mem_req && mem_ack)
    begin
      last_ff <= mem_rdata;
      if (mem_we)
        wq.push_back({mem_addr, mem_wdata});
      if (mem_we)
        mem[mem_addr[15:1]] <= mem_wdata;
    end
    if (irq_ack)
      acked <= 1'b1;
  end
  // one-cycle ack; irq dropped after acknowledge
  always @(negedge clk)
  begin
    if (mem_ack)
      mem_ack <= 1'b0;
    else if (mem_req && cnt >= lat)
      mem_ack <= 1'b1;
    cnt <= (mem_req && !mem_ack && cnt < lat) ? cnt + 1 : 0;
    if (acked)
      irq_req <= 1'b0;
    acked <= 1'b0;
  end
  task automatic poke(input logic [15:0] a, d);
    mem[a[15:1]] = d;
  endtask : poke
  task automatic raise(input logic [15:0] v);
    vec = v;
    irq_req = 1'b1;
  endtask : raise
endmodule : far_side

// File: verif/operand_mode_and_stack_sequencer_tb.sv
`timescale 1ns/1ns
module operand_mode_and_stack_sequencer_tb;
  import opseq_pkg::*;
  logic clk, sys_rst, cmd_valid, cmd_ready, cmd_byte, irq_req, irq_ack, op_done;
  logic mem_req, mem_we, mem_word, mem_ack, mem_seen;
  op_t cmd_op;
  logic [2:0] cmd_src_mode, cmd_src_reg, cmd_dst_mode, cmd_dst_reg, cmd_link_reg;
  logic [15:0] cmd_vector, irq_vector, mem_addr, mem_wdata, mem_rdata;
  logic [15:0] src_addr, dst_addr, pc_out, sp_out, processor_status_word;
  int bad_count, comparisons, done_at;
  operand_mode_and_stack_sequencer operand_mode_and_stack_sequencer_i (.clk, .sys_rst,
    .cmd_valid, .cmd_ready, .cmd_op, .cmd_byte, .cmd_src_mode, .cmd_src_reg, .cmd_dst_mode,
    .cmd_dst_reg, .cmd_link_reg, .cmd_vector, .irq_req, .irq_vector, .irq_ack, .mem_req,
    .mem_we, .mem_word, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .op_done, .src_addr,
    .dst_addr, .pc_out, .sp_out, .processor_status_word);
  far_side far_side_i (.clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_ack, .irq_ack, .irq_req, .irq_vector);
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // four idle cycles with no bus traffic
  task automatic settle();
    int idle;
    idle = 0;
    for (int n = 1; n < 400 && idle < 4; n++)
    begin
      @(negedge clk);
      cmd_valid = 1'b0;
      if (op_done === 1'b1)
        done_at = n;
      mem_seen |= (mem_req === 1'b1);
      if (mem_req === 1'b1)
        chk("word addr lsb", 16'(mem_addr[0]), 16'h0000);
      idle = (cmd_ready === 1'b1 && mem_req === 1'b0) ? idle + 1 : 0;
    end
    chk("settled", 16'(idle), 16'h0004);
  endtask : settle
  task automatic cmd(input op_t op, input logic b, input logic [5:0] s, d);
    @(negedge clk);
    cmd_op = op;
    cmd_byte = b;
    {cmd_src_mode, cmd_src_reg} = s;
    {cmd_dst_mode, cmd_dst_reg} = d;
    cmd_valid = 1'b1;
    done_at = 0;
    mem_seen = 1'b0;
    for (int i = 0; i < 100 && cmd_ready !== 1'b1; i++)
      @(negedge clk);
    @(posedge clk);
    settle();
  endtask : cmd
  task automatic irq(input logic [15:0] v);
    @(negedge clk);
    far_side_i.raise(v);
    repeat (3) @(negedge clk);
    settle();
  endtask : irq
  task automatic wr(input logic [15:0] a, d);
    logic [31:0] w;
    w = far_side_i.wq.pop_front();
    chk("push addr", w[31:16], a);
    chk("push data", w[15:0], d);
  endtask : wr
  task automatic st(input logic [15:0] pc, sp, ps);
    chk("pc", pc_out, pc);
    chk("sp", sp_out, sp);
    chk("psw", processor_status_word, ps);
  endtask : st
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    st(PC_RST, SP_RST, PSW_RST);
    chk("ready", 16'(cmd_ready), 16'h0001);
    chk("req", 16'(mem_req), 16'h0000);
  endtask : t_reset
  task automatic t_operate();
    cmd(OP_OPERATE, 1'b0, 6'h00, 6'h00);
    chk("operate done", 16'(done_at), 16'h0002);
    chk("operate bus", 16'(mem_seen), 16'h0000);
  endtask : t_operate
  task automatic t_pcmodes();
    cmd(OP_SINGLE, 1'b1, 6'h00, {MODE_INC, PC_IDX});
    chk("imm addr", dst_addr, 16'h0200);
    chk("imm pc", pc_out, 16'h0202);
    far_side_i.poke(16'h0202, 16'h0abc);
    cmd(OP_SINGLE, 1'b0, 6'h00, {MODE_INC_DEF, PC_IDX});
    chk("abs addr", dst_addr, 16'h0abc);
    far_side_i.poke(16'h0204, 16'h0100);
    cmd(OP_SINGLE, 1'b0, 6'h00, {MODE_IDX, PC_IDX});
    chk("rel addr", dst_addr, 16'h0306);
    far_side_i.poke(16'h0206, 16'h0010);
    far_side_i.poke(16'h0218, 16'h0456);
    cmd(OP_SINGLE, 1'b0, 6'h00, {MODE_IDX_DEF, PC_IDX});
    chk("rel def addr", dst_addr, 16'h0456);
    chk("rel def pc", pc_out, 16'h0208);
  endtask : t_pcmodes
  task automatic t_steps();
    cmd(OP_SINGLE, 1'b1, 6'h00, {MODE_INC, 3'h3});
    chk("byte inc", dst_addr, 16'h0000);
    cmd(OP_DOUBLE, 1'b1, {MODE_INC, 3'h3}, {MODE_INC, 3'h3});
    chk("src first", src_addr, 16'h0001);
    chk("dst second", dst_addr, 16'h0002);
    cmd(OP_DOUBLE, 1'b1, {MODE_DEC, 3'h3}, {MODE_DEF, 3'h3});
    chk("byte dec", src_addr, 16'h0002);
    cmd(OP_SINGLE, 1'b0, {MODE_INC, 3'h3}, {MODE_INC, 3'h3});
    chk("single no src", dst_addr, 16'h0002);
    cmd(OP_SINGLE, 1'b0, 6'h00, {MODE_DEF, 3'h3});
    chk("word step", dst_addr, 16'h0004);
    cmd(OP_SINGLE, 1'b1, 6'h00, {MODE_INC, SP_IDX});
    chk("sp byte inc", sp_out, 16'h1002);
    cmd(OP_SINGLE, 1'b1, 6'h00, {MODE_DEC, SP_IDX});
    chk("sp byte dec", dst_addr, 16'h1000);
  endtask : t_steps
  task automatic t_call();
    cmd(OP_CALL, 1'b0, 6'h00, {MODE_REG, 3'h3});
    wr(16'h0ffe, 16'h0000);
    st(16'h0004, 16'h0ffe, PSW_RST);
    cmd(OP_SINGLE, 1'b0, 6'h00, {MODE_REG, 3'h5});
    chk("link pc", dst_addr, 16'h0208);
    far_side_i.lat = 3;
    cmd(OP_RETURN, 1'b0, 6'h00, 6'h00);
    st(16'h0208, SP_RST, PSW_RST);
    cmd(OP_SINGLE, 1'b0, 6'h00, {MODE_REG, 3'h5});
    chk("link popped", dst_addr, 16'h0000);
  endtask : t_call
  task automatic t_irq();
    far_side_i.poke(16'h0040, 16'h0300);
    far_side_i.poke(16'h0042, 16'h0003);
    far_side_i.poke(16'h0050, 16'h0340);
    far_side_i.poke(16'h0052, 16'h0005);
    irq(16'h0040);
    wr(16'h0ffe, PSW_RST);
    wr(16'h0ffc, 16'h0208);
    st(16'h0300, 16'h0ffc, 16'h0003);
    irq(16'h0050);
    wr(16'h0ffa, 16'h0003);
    wr(16'h0ff8, 16'h0300);
    st(16'h0340, 16'h0ff8, 16'h0005);
    cmd(OP_RTI, 1'b0, 6'h00, 6'h00);
    st(16'h0300, 16'h0ffc, 16'h0003);
    cmd(OP_RTI, 1'b0, 6'h00, 6'h00);
    st(16'h0208, SP_RST, PSW_RST);
  endtask : t_irq
  task automatic t_trap();
    far_side_i.lat = 0;
    far_side_i.poke(16'h0020, 16'h0400);
    far_side_i.poke(16'h0022, 16'h0010);
    far_side_i.poke(VEC_TRACE, 16'h0500);
    far_side_i.poke(VEC_ODD, 16'h0600);
    cmd_vector = 16'h0020;
    cmd(OP_TRAP, 1'b0, 6'h00, 6'h00);
    wr(16'h0ffe, PSW_RST);
    wr(16'h0ffc, 16'h0208);
    st(16'h0400, 16'h0ffc, 16'h0010);
    cmd(OP_OPERATE, 1'b0, 6'h00, 6'h00);
    wr(16'h0ffa, 16'h0010);
    wr(16'h0ff8, 16'h0400);
    st(16'h0500, 16'h0ff8, PSW_RST);
    cmd(OP_SINGLE, 1'b1, 6'h00, {MODE_INC, 3'h3});
    cmd(OP_SINGLE, 1'b0, 6'h00, {MODE_INC_DEF, 3'h3});
    wr(16'h0ff6, PSW_RST);
    wr(16'h0ff4, 16'h0500);
    st(16'h0600, 16'h0ff4, PSW_RST);
  endtask : t_trap
  // ---------------------------------------------------------------
  // clock, sequence, watchdog
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    {sys_rst, cmd_valid, cmd_byte, bad_count, comparisons} = {3'h4, 64'h0};
    {cmd_src_mode, cmd_src_reg, cmd_dst_mode, cmd_dst_reg} = 12'h000;
    cmd_op = OP_OPERATE;
    cmd_link_reg = 3'h5;
    cmd_vector = 16'h0000;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_operate();
    t_pcmodes();
    t_steps();
    t_call();
    t_irq();
    t_trap();
    tally_and_finish();
  end
  // scenarios need a few hundred cycles
  initial
  begin
    #2000000;
    bad_count++;
    tally_and_finish();
  end
endmodule : operand_mode_and_stack_sequencer_tb
